// ---- design/rivec_pkg.sv ----
// Package for reset and interrupt vectoring unit
package rivec_pkg;
  localparam int          PC_W         = 11;
  localparam int          STK_DEPTH    = 8;
  localparam int          STK_PTR_W    = 3;
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  localparam logic [10:0] IRQ_VECTOR   = 11'h008;
  localparam logic [10:0] VECTOR_WORDS = 11'h001;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam int          TO_BIT       = 7;
  localparam int          PD_BIT       = 6;
  localparam logic [7:0]  CAUSE_MASK   = 8'hc0;

  typedef enum logic [2:0] {
    RIVEC_CAUSE_POR = 3'b001,
    RIVEC_CAUSE_WDT = 3'b010,
    RIVEC_CAUSE_EXT = 3'b100
  } rivec_cause_t;

  typedef enum logic [2:0] {
    RIVEC_ST_RESET = 3'b001,
    RIVEC_ST_RUN   = 3'b010,
    RIVEC_ST_IRQ   = 3'b100
  } rivec_state_t;

  typedef struct packed {
    logic       save;
    logic       restore;
    logic [7:0] acc;
    logic [7:0] flags;
  } rivec_ctx_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
  } rivec_ctx_t;

  typedef struct packed {
    rivec_state_t              st;
    logic [PC_W-1:0]           pc;
    logic [STK_DEPTH-1:0][PC_W-1:0] stk;
    logic [STK_PTR_W-1:0]      sp;
    rivec_ctx_t                ctx;
    logic                      to_flag;
    logic                      pd_flag;
    logic                      sys_reset;
  } rivec_state_s_t;
endpackage : rivec_pkg

// ---- design/rivec_top.sv ----
// Reset and interrupt vectoring with reset cause flags and context buffer
`timescale 1ns/1ns

module rivec_top
  import rivec_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Reset sources
  input  wire logic            por_req,
  input  wire logic            wdt_ovf,
  input  wire logic            ext_rst_en,
  input  wire logic            shared_input_pin,
  // Core sequencing
  input  wire logic            fetch_adv,
  input  wire logic            irq_take,
  input  wire logic            call_req,
  input  wire logic            ret_req,
  input  wire logic            interrupt_return,
  input  wire logic            jump_req,
  input  wire logic [PC_W-1:0] jump_addr,
  // Context save and restore
  input  wire rivec_ctx_req_t  ctx_req,
  // Outputs
  output logic [PC_W-1:0]      fetch_addr,
  output logic                 sys_reg_default,
  output rivec_ctx_t           ctx_out,
  output logic [7:0]           program_flags_register,
  output logic                 timeout_reset_flag,
  output logic                 power_down_flag,
  output logic                 pin_level,
  output logic                 pin_wakeup,
  output logic                 in_vector
);

  rivec_state_s_t s_q;
  rivec_state_s_t s_d;
  logic           pin_prev_q;
  logic           ext_rst_req;
  rivec_cause_t   cause;

  function automatic logic [STK_PTR_W-1:0] ptr_step(input logic [STK_PTR_W-1:0] p, input logic up);
    ptr_step = up ? STK_PTR_W'(p + 1'b1) : STK_PTR_W'(p - 1'b1);
  endfunction : ptr_step

  assign ext_rst_req = ext_rst_en & ~shared_input_pin;

  always_comb begin
    if (por_req) begin
      cause = RIVEC_CAUSE_POR;
    end else if (wdt_ovf) begin
      cause = RIVEC_CAUSE_WDT;
    end else begin
      cause = RIVEC_CAUSE_EXT;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.sys_reset = 1'b0;
    if (por_req || wdt_ovf || ext_rst_req) begin
      s_d.st        = RIVEC_ST_RESET;
      s_d.pc        = RESET_VECTOR;
      s_d.sp        = '0;
      s_d.ctx       = '{acc: ACC_RESET, flags: FLAGS_RESET};
      s_d.sys_reset = 1'b1;
      case (cause)
        RIVEC_CAUSE_POR: begin
          s_d.to_flag = 1'b1;
          s_d.pd_flag = 1'b0;
        end
        RIVEC_CAUSE_WDT: begin
          s_d.to_flag = 1'b0;
          s_d.pd_flag = 1'b0;
        end
        RIVEC_CAUSE_EXT: begin
          s_d.to_flag = 1'b1;
          s_d.pd_flag = 1'b1;
        end
        default: begin
          s_d.to_flag = 1'b1;
          s_d.pd_flag = 1'b0;
        end
      endcase
    end else begin
      case (s_q.st)
        RIVEC_ST_RESET: begin
          s_d.st = RIVEC_ST_RUN;
        end
        RIVEC_ST_RUN, RIVEC_ST_IRQ: begin
          if (irq_take) begin
            s_d.stk[s_q.sp] = s_q.pc;
            s_d.sp          = ptr_step(s_q.sp, 1'b1);
            s_d.pc          = IRQ_VECTOR;
            s_d.st          = RIVEC_ST_IRQ;
          end else if (call_req) begin
            s_d.stk[s_q.sp] = PC_W'(s_q.pc + 1'b1);
            s_d.sp          = ptr_step(s_q.sp, 1'b1);
            s_d.pc          = jump_addr;
          end else if (interrupt_return || ret_req) begin
            s_d.sp = ptr_step(s_q.sp, 1'b0);
            s_d.pc = s_q.stk[ptr_step(s_q.sp, 1'b0)];
            if (interrupt_return) begin
              s_d.st = RIVEC_ST_RUN;
            end
          end else if (jump_req) begin
            s_d.pc = jump_addr;
          end else if (fetch_adv) begin
            s_d.pc = PC_W'(s_q.pc + 1'b1);
          end
        end
        default: begin
          s_d.st = RIVEC_ST_RUN;
        end
      endcase
      if (ctx_req.save) begin
        s_d.ctx.acc   = ctx_req.acc;
        s_d.ctx.flags = ctx_req.flags & ~CAUSE_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q        <= '{st: RIVEC_ST_RESET, pc: RESET_VECTOR, stk: '0, sp: '0,
                      ctx: '0, to_flag: 1'b1, pd_flag: 1'b0, sys_reset: 1'b1};
      pin_prev_q <= 1'b1;
    end else begin
      s_q        <= s_d;
      pin_prev_q <= shared_input_pin;
    end
  end

  // Outputs
  assign fetch_addr      = s_q.pc;
  assign sys_reg_default = s_q.sys_reset;
  assign timeout_reset_flag = s_q.to_flag;
  assign power_down_flag    = s_q.pd_flag;
  assign program_flags_register = {s_q.to_flag, s_q.pd_flag, 6'h00};
  assign ctx_out.acc   = s_q.ctx.acc;
  // Restore keeps live cause bits
  assign ctx_out.flags = (s_q.ctx.flags & ~CAUSE_MASK) | (program_flags_register & CAUSE_MASK);
  assign pin_level  = ext_rst_en ? 1'b1 : shared_input_pin;
  assign pin_wakeup = ~ext_rst_en & (pin_prev_q ^ shared_input_pin);
  assign in_vector  = (s_q.pc < VECTOR_WORDS) || (s_q.pc == IRQ_VECTOR);

endmodule : rivec_top

// ---- verification/rivec_pin_drv.sv ----
// External reset pin driver model
`timescale 1ns/1ns
module rivec_pin_drv (
  // Control
  input  logic pull,
  input  logic lvl,
  // Pin
  output logic pin
);
  assign pin = pull ? 1'b0 : lvl;
endmodule : rivec_pin_drv

// ---- verification/rivec_assertions.sv ----
// Assertion checker for the vectoring unit
`timescale 1ns/1ns
module rivec_assertions
  import rivec_pkg::*;
(
  // Clock and reset
  input logic clk, rst_n,
  // Requests
  input logic por_req, wdt_ovf, ext_rst_en, shared_input_pin, irq_take, call_req, interrupt_return,
  input rivec_ctx_req_t ctx_req,
  // Results
  input logic [PC_W-1:0] fetch_addr,
  input rivec_ctx_t ctx_out,
  input logic [7:0] program_flags_register,
  input logic sys_reg_default, timeout_reset_flag, power_down_flag, pin_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ext = ext_rst_en & !shared_input_pin;
  wire any = por_req | wdt_ovf | ext;
  wire ok  = !any & !sys_reg_default;
  reset_vec_a: assert property (any |=> fetch_addr == 11'h000 && sys_reg_default) else $error("bad reset");
  por_flag_a: assert property (por_req |=> timeout_reset_flag && !power_down_flag) else $error("bad por");
  wdt_flag_a: assert property (wdt_ovf && !por_req |=> !timeout_reset_flag && !power_down_flag) else $error("bad wdt");
  ext_flag_a: assert property (ext && !wdt_ovf && !por_req |=> timeout_reset_flag && power_down_flag) else $error("bad ext");
  program_flags_register_view_a: assert property (program_flags_register == {timeout_reset_flag, power_down_flag, 6'h00}) else $error("program_flags_register");
  irq_vec_a: assert property (irq_take && ok |=> fetch_addr == IRQ_VECTOR) else $error("bad irq");
  irq_ret_a: assert property (irq_take && ok ##1 interrupt_return && ok && !irq_take && !call_req
    |=> fetch_addr == $past(fetch_addr, 2)) else $error("bad return");
  ctx_save_a: assert property (ctx_req.save && ok |=> ctx_out == {$past(ctx_req.acc), timeout_reset_flag,
    power_down_flag, $past(ctx_req.flags[5:0])}) else $error("bad save");
  pin_in_a: assert property (!ext_rst_en |-> pin_level == shared_input_pin) else $error("bad pin");
  cover property (irq_take && ok);
  cover property (ext);
  cover property (ctx_req.save && ok);
endmodule : rivec_assertions
bind rivec_top rivec_assertions u_rivec_assertions (.clk, .rst_n, .por_req, .wdt_ovf, .ext_rst_en, .shared_input_pin,
  .irq_take, .call_req, .interrupt_return, .ctx_req, .fetch_addr, .ctx_out, .program_flags_register,
  .sys_reg_default, .timeout_reset_flag, .power_down_flag, .pin_level);

// ---- verification/tb_rivec_top.sv ----
// Self-checking bench for the vectoring unit
`timescale 1ns/1ns
module tb_rivec_top;
  import rivec_pkg::*;
  logic clk = 0, rst_n = 0, por_req = 0, wdt_ovf = 0, ext_rst_en = 1, pull = 0, lvl = 1;
  logic irq_take = 0, interrupt_return = 0, jump_req = 0, save = 0;
  logic fetch_adv = 0, call_req = 0, ret_req = 0, prv = 1;
  wire srd, inv, wake;
  logic [PC_W-1:0] jump_addr = 0, a [8];
  logic [7:0] acc = 0, flg = 0;
  wire pin, to_f, pd_f, lvl_o;
  wire [PC_W-1:0] pc;
  rivec_ctx_t ctx;
  int n_fail = 0, samples_checked = 0, seed = 14, cyc = 0;
  rivec_top u_rivec_top (.clk, .rst_n, .por_req, .wdt_ovf, .ext_rst_en, .shared_input_pin(pin), .fetch_adv,
    .irq_take, .call_req, .ret_req, .interrupt_return, .jump_req, .jump_addr,
    .ctx_req({save, 1'b0, acc, flg}), .fetch_addr(pc), .sys_reg_default(srd), .ctx_out(ctx),
    .program_flags_register(), .timeout_reset_flag(to_f), .power_down_flag(pd_f), .pin_level(lvl_o),
    .pin_wakeup(wake), .in_vector(inv));
  rivec_pin_drv u_rivec_pin_drv (.pull, .lvl, .pin);
  task automatic step; @(posedge clk); #1; endtask : step
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  function automatic logic [1:0] exp_flags(input int src);
    return src == 0 ? 2'b10 : src == 1 ? 2'b00 : 2'b11;
  endfunction : exp_flags
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin
    n_fail++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    step;
    step;
    for (int i = 0; i < 3; i++) begin
      por_req = i == 0;
      wdt_ovf = i == 1;
      pull = i == 2;
      step;
      {por_req, wdt_ovf, pull} = 3'h0;
      cmp(16'(pc), 16'h0000);
      cmp({14'h0, to_f, pd_f}, {14'h0, exp_flags(i)});
      cmp(16'(srd), 16'h0001);
      cmp(16'(inv), 16'h0001);
      step;
      cmp(16'(srd), 16'h0000);
    end
    step;
    for (int k = 0; k < 8; k++) begin
      a[k] = 11'($random(seed));
      jump_addr = a[k];
      jump_req = 1;
      step;
      jump_req = 0;
      irq_take = 1;
      step;
      irq_take = 0;
      cmp(16'(pc), 16'(IRQ_VECTOR));
    end
    interrupt_return = 1;
    for (int k = 7; k >= 0; k--) begin
      step;
      cmp(16'(pc), 16'(a[k]));
    end
    interrupt_return = 0;
    save = 1;
    for (int k = 0; k < 2; k++) begin
      acc = 8'($random(seed));
      flg = 8'($random(seed));
      step;
    end
    save = 0;
    cmp({ctx.acc, ctx.flags}, {acc, 2'b11, flg[5:0]});
    jump_addr = 11'h123;
    jump_req = 1;
    step;
    jump_req = 0;
    fetch_adv = 1;
    step;
    fetch_adv = 0;
    jump_addr = 11'h008;
    call_req = 1;
    step;
    call_req = 0;
    cmp(16'(pc), 16'h0008);
    cmp(16'(inv), 16'h0001);
    ret_req = 1;
    step;
    ret_req = 0;
    cmp(16'(pc), 16'h0125);
    cmp(16'(inv), 16'h0000);
    ext_rst_en = 0;
    for (int k = 0; k < 8; k++) begin
      prv = lvl;
      lvl = 1'($random(seed));
      #1;
      cmp(16'(wake), 16'(prv ^ lvl));
      step;
      cmp(16'(lvl_o), 16'(lvl));
    end
    rst_n = 0;
    step;
    cmp(16'(pc), 16'h0000);
    cmp({14'h0, to_f, pd_f}, {14'h0, exp_flags(0)});
    rst_n = 1;
    step;
    step;
    cmp(16'(srd), 16'h0000);
    final_report;
  end
endmodule : tb_rivec_top
